// File: rtl/ixe_pkg.sv
/*
 * Shared constants for the instruction execution unit: operation codes,
 * flag positions, register offsets and reset values.
 * Assumes a 32-bit AXI4-Lite register bus and an 8-bit data path.
 */
package ixe_pkg;

	// ----------------------------------------------------------------
	// Operation codes
	// ----------------------------------------------------------------
	localparam logic [4:0] OP_NOP          = 5'h00;
	localparam logic [4:0] OP_SET_BYTE     = 5'h01;
	localparam logic [4:0] OP_SET_BIT      = 5'h02;
	localparam logic [4:0] OP_INC_SKIP     = 5'h03;
	localparam logic [4:0] OP_INC_ACC_SKIP = 5'h04;
	localparam logic [4:0] OP_BIT_NZ_SKIP  = 5'h05;
	localparam logic [4:0] OP_SUB_ACC      = 5'h06;
	localparam logic [4:0] OP_SUB_MEM      = 5'h07;
	localparam logic [4:0] OP_SUB_IMM      = 5'h08;
	localparam logic [4:0] OP_SWAP_MEM     = 5'h09;
	localparam logic [4:0] OP_SWAP_ACC     = 5'h0a;
	localparam logic [4:0] OP_ZERO_SKIP    = 5'h0b;
	localparam logic [4:0] OP_COPY_SKIP    = 5'h0c;
	localparam logic [4:0] OP_BIT_Z_SKIP   = 5'h0d;
	localparam logic [4:0] OP_TAB_PAGED    = 5'h0e;
	localparam logic [4:0] OP_TAB_LAST     = 5'h0f;
	localparam logic [4:0] OP_XOR_ACC      = 5'h10;
	localparam logic [4:0] OP_XOR_MEM      = 5'h11;
	localparam logic [4:0] OP_XOR_IMM      = 5'h12;

	// ----------------------------------------------------------------
	// Status flag positions
	// ----------------------------------------------------------------
	localparam int FLAG_C  = 0;
	localparam int FLAG_AC = 1;
	localparam int FLAG_Z  = 2;
	localparam int FLAG_OV = 3;

	// ----------------------------------------------------------------
	// Register byte addresses
	// ----------------------------------------------------------------
	localparam logic [7:0] REG_CMD     = 8'h00;
	localparam logic [7:0] REG_ACC     = 8'h04;
	localparam logic [7:0] REG_FLAGS   = 8'h08;
	localparam logic [7:0] REG_TBL_PTR = 8'h0c;
	localparam logic [7:0] REG_TBL_HI  = 8'h10;
	localparam logic [7:0] REG_STATUS  = 8'h14;
	localparam logic [7:0] REG_MEM_WIN = 8'h80;

	// ----------------------------------------------------------------
	// Command register fields
	// ----------------------------------------------------------------
	localparam int CMD_OP_LSB   = 0;
	localparam int CMD_BIT_LSB  = 8;
	localparam int CMD_ADDR_LSB = 16;
	localparam int CMD_IMM_LSB  = 24;

	// ----------------------------------------------------------------
	// Sizes and reset values
	// ----------------------------------------------------------------
	localparam int         MEM_WORDS     = 32;
	localparam int         PROG_WORDS    = 256;
	localparam logic [7:0] LAST_PAGE     = 8'hff;
	localparam logic [7:0] ACC_RESET     = 8'h00;
	localparam logic [3:0] FLAGS_RESET   = 4'h0;
	localparam logic [1:0] RESP_OKAY     = 2'b00;
	localparam logic [1:0] RESP_SLVERR   = 2'b10;

endpackage

// File: rtl/ixe_alu.sv
/*
 * Combinational data path: result byte, new flags and skip decision.
 * Assumes operands are stable for the cycle in which they are used.
 */
`timescale 1ns/1ps
module ixe_alu
(
	// Operation and operands
	input  wire logic [4:0]  op,
	input  wire logic [2:0]  bit_sel,
	input  wire logic [7:0]  acc,
	input  wire logic [7:0]  mem,
	input  wire logic [7:0]  imm,
	input  wire logic [3:0]  flags_in,
	// Results
	output logic      [7:0]  result,
	output logic             to_mem,
	output logic             to_acc,
	output logic      [3:0]  flags_out,
	output logic             skip
);

	logic [8:0] diff;
	logic [4:0] low_diff;
	logic [7:0] subtrahend;
	logic [7:0] inc;
	logic [7:0] bit_mask;

	assign subtrahend = (op == ixe_pkg::OP_SUB_IMM) ? imm : mem;
	assign diff       = {1'b0, acc} - {1'b0, subtrahend};
	assign low_diff   = {1'b0, acc[3:0]} - {1'b0, subtrahend[3:0]};
	assign inc        = mem + 8'h01;
	assign bit_mask   = 8'h01 << bit_sel;

	always_comb
	begin
		result    = mem;
		to_mem    = 1'b0;
		to_acc    = 1'b0;
		flags_out = flags_in;
		skip      = 1'b0;
		unique case (op)
			ixe_pkg::OP_SET_BYTE:
			begin
				result = 8'hff;
				to_mem = 1'b1;
			end
			ixe_pkg::OP_SET_BIT:
			begin
				result = mem | bit_mask;
				to_mem = 1'b1;
			end
			ixe_pkg::OP_INC_SKIP:
			begin
				result = inc;
				to_mem = 1'b1;
				skip   = (inc == 8'h00);
			end
			ixe_pkg::OP_INC_ACC_SKIP:
			begin
				result = inc;
				to_acc = 1'b1;
				skip   = (inc == 8'h00);
			end
			ixe_pkg::OP_BIT_NZ_SKIP:
				skip = |(mem & bit_mask);
			ixe_pkg::OP_SUB_ACC, ixe_pkg::OP_SUB_MEM, ixe_pkg::OP_SUB_IMM:
			begin
				result = diff[7:0];
				to_acc = (op != ixe_pkg::OP_SUB_MEM);
				to_mem = (op == ixe_pkg::OP_SUB_MEM);
				// Carry is the inverted borrow: set on a zero or positive result.
				flags_out[ixe_pkg::FLAG_C]  = ~diff[8];
				flags_out[ixe_pkg::FLAG_AC] = ~low_diff[4];
				flags_out[ixe_pkg::FLAG_Z]  = (diff[7:0] == 8'h00);
				flags_out[ixe_pkg::FLAG_OV] = (acc[7] ^ subtrahend[7]) & (acc[7] ^ diff[7]);
			end
			ixe_pkg::OP_SWAP_MEM, ixe_pkg::OP_SWAP_ACC:
			begin
				result = {mem[3:0], mem[7:4]};
				to_mem = (op == ixe_pkg::OP_SWAP_MEM);
				to_acc = (op == ixe_pkg::OP_SWAP_ACC);
			end
			ixe_pkg::OP_ZERO_SKIP:
			begin
				to_mem = 1'b1;
				skip   = (mem == 8'h00);
			end
			ixe_pkg::OP_COPY_SKIP:
			begin
				to_acc = 1'b1;
				skip   = (mem == 8'h00);
			end
			ixe_pkg::OP_BIT_Z_SKIP:
				skip = ~|(mem & bit_mask);
			ixe_pkg::OP_XOR_ACC, ixe_pkg::OP_XOR_MEM, ixe_pkg::OP_XOR_IMM:
			begin
				result = acc ^ ((op == ixe_pkg::OP_XOR_IMM) ? imm : mem);
				to_acc = (op != ixe_pkg::OP_XOR_MEM);
				to_mem = (op == ixe_pkg::OP_XOR_MEM);
				flags_out[ixe_pkg::FLAG_Z] = (result == 8'h00);
			end
			default:
			begin
				result = mem;
			end
		endcase
	end

endmodule

// File: rtl/ixe_core.sv
/*
 * Instruction execution unit with an AXI4-Lite register port.
 * Software writes a command word; the unit runs it against a small data
 * memory, the accumulator, the flags and a program table, then reports
 * whether the next instruction is to be skipped.
 * Assumes one clock, synchronous active-low reset and a well-behaved master.
 */
// The register addresses and the AXI4-Lite register port were chosen for this implementation.
// What this block does
// - Byte set writes all ones, flags kept.
// - Bit set forces one bit, flags kept.
// - Increment memory, skip when result zero.
// - Increment into accumulator, skip when zero.
// - Skip when selected bit is one.
// - Accumulator minus memory, to accumulator or memory.
// - Immediate subtract; carry set unless negative.
// - Swap nibbles into memory or accumulator.
// - Rewrite byte, skip when it is zero.
// - Copy byte to accumulator, skip when zero.
// - Skip when selected bit is zero.
// - Paged table read via low pointer byte only.
// - Last page table read via low pointer.
// - Exclusive-or memory into accumulator, zero flag.
// - Exclusive-or into memory, zero flag only.
// - Exclusive-or immediate into accumulator, zero flag.
`timescale 1ns/1ps
module ixe_core
(
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// Write address channel
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	// Write data channel
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	// Write response channel
	output logic      [1:0]  s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// Read address channel
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	// Read data channel
	output logic      [31:0] s_axi_rdata,
	output logic      [1:0]  s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Program table load port
	input  wire logic        prog_we,
	input  wire logic [7:0]  prog_addr,
	input  wire logic [15:0] prog_wdata
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef enum logic [2:0]
	{
		ST_IDLE  = 3'b001,
		ST_EXEC  = 3'b010,
		ST_DUMMY = 3'b100
	} ixe_state_t;

	ixe_state_t  state_reg;
	logic [7:0]  data_mem [ixe_pkg::MEM_WORDS];
	logic [15:0] prog_mem [ixe_pkg::PROG_WORDS];
	logic [7:0]  acc_reg;
	logic [3:0]  flags_reg;
	logic [7:0]  tbl_ptr_lo_reg;
	logic [7:0]  tbl_ptr_hi_reg;
	logic [7:0]  tbl_hi_reg;
	logic [31:0] cmd_reg;
	logic        skipped_reg;
	logic [7:0]  aw_addr_reg;
	logic        aw_held_reg;
	logic [31:0] w_data_reg;
	logic [3:0]  w_strb_reg;
	logic        w_held_reg;

	logic [4:0]  op;
	logic [4:0]  mem_idx;
	logic [7:0]  mem_rd;
	logic [7:0]  alu_result;
	logic        alu_to_mem;
	logic        alu_to_acc;
	logic [3:0]  alu_flags;
	logic        alu_skip;
	logic [15:0] prog_word;
	logic        is_table;
	logic        wr_fire;
	logic        busy;

	assign op      = cmd_reg[ixe_pkg::CMD_OP_LSB +: 5];
	assign mem_idx = cmd_reg[ixe_pkg::CMD_ADDR_LSB +: 5];
	assign mem_rd  = data_mem[mem_idx];
	assign busy    = (state_reg != ST_IDLE);
	assign is_table = (op == ixe_pkg::OP_TAB_PAGED) || (op == ixe_pkg::OP_TAB_LAST);

	// Paged and last page reads share one lookup; the high pointer byte is not used.
	// With a 256-word table only the low pointer selects the word.
	assign prog_word = prog_mem[tbl_ptr_lo_reg];

	ixe_alu u_alu
	(
		.op        (op),
		.bit_sel   (cmd_reg[ixe_pkg::CMD_BIT_LSB +: 3]),
		.acc       (acc_reg),
		.mem       (mem_rd),
		.imm       (cmd_reg[ixe_pkg::CMD_IMM_LSB +: 8]),
		.flags_in  (flags_reg),
		.result    (alu_result),
		.to_mem    (alu_to_mem),
		.to_acc    (alu_to_acc),
		.flags_out (alu_flags),
		.skip      (alu_skip)
	);

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state_reg   <= ST_IDLE;
			skipped_reg <= 1'b0;
		end
		else
		begin
			unique case (state_reg)
				ST_IDLE:
					if (wr_fire && aw_addr_reg == ixe_pkg::REG_CMD)
						state_reg <= ST_EXEC;
				ST_EXEC:
				begin
					skipped_reg <= alu_skip;
					// The skipped instruction is replaced by a dummy cycle.
					state_reg   <= alu_skip ? ST_DUMMY : ST_IDLE;
				end
				ST_DUMMY:
					state_reg <= ST_IDLE;
				default:
					state_reg <= ST_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Data memory, program table, accumulator and flags
	// ----------------------------------------------------------------
	always_ff @(posedge aclk)
	begin
		if (state_reg == ST_EXEC && is_table)
			data_mem[mem_idx] <= prog_word[7:0];
		else if (state_reg == ST_EXEC && alu_to_mem)
			data_mem[mem_idx] <= alu_result;
		else if (wr_fire && !busy && aw_addr_reg[7] && w_strb_reg[0])
			data_mem[aw_addr_reg[6:2]] <= w_data_reg[7:0];
	end

	always_ff @(posedge aclk)
	begin
		if (prog_we)
			prog_mem[prog_addr] <= prog_wdata;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			acc_reg    <= ixe_pkg::ACC_RESET;
			flags_reg  <= ixe_pkg::FLAGS_RESET;
			tbl_hi_reg <= 8'h00;
		end
		else if (state_reg == ST_EXEC)
		begin
			if (alu_to_acc)
				acc_reg <= alu_result;
			flags_reg <= alu_flags;
			if (is_table)
				tbl_hi_reg <= prog_word[15:8];
		end
		else if (wr_fire && !busy)
		begin
			if (aw_addr_reg == ixe_pkg::REG_ACC && w_strb_reg[0])
				acc_reg <= w_data_reg[7:0];
			if (aw_addr_reg == ixe_pkg::REG_FLAGS && w_strb_reg[0])
				flags_reg <= w_data_reg[3:0];
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			cmd_reg        <= 32'h0000_0000;
			tbl_ptr_lo_reg <= 8'h00;
			tbl_ptr_hi_reg <= 8'h00;
		end
		else if (wr_fire && !busy)
		begin
			if (aw_addr_reg == ixe_pkg::REG_CMD)
				cmd_reg <= w_data_reg;
			if (aw_addr_reg == ixe_pkg::REG_TBL_PTR)
			begin
				if (w_strb_reg[0])
					tbl_ptr_lo_reg <= w_data_reg[7:0];
				if (w_strb_reg[1])
					tbl_ptr_hi_reg <= w_data_reg[15:8];
			end
		end
	end

	// ----------------------------------------------------------------
	// AXI4-Lite write path
	// ----------------------------------------------------------------
	// Address and data are latched separately; the write completes once both
	// are held and no command is running, so a command never sees its
	// operands change mid-flight.
	assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
	assign s_axi_wready  = !w_held_reg && !s_axi_bvalid;
	assign wr_fire       = aw_held_reg && w_held_reg && !busy && !s_axi_bvalid;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held_reg  <= 1'b0;
			w_held_reg   <= 1'b0;
			aw_addr_reg  <= 8'h00;
			w_data_reg   <= 32'h0000_0000;
			w_strb_reg   <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= ixe_pkg::RESP_OKAY;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_held_reg <= 1'b1;
				aw_addr_reg <= {s_axi_awaddr[7:2], 2'b00};
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_held_reg <= 1'b1;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end
			if (wr_fire)
			begin
				aw_held_reg  <= 1'b0;
				w_held_reg   <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (aw_addr_reg[7] || aw_addr_reg <= ixe_pkg::REG_TBL_PTR)
				                ? ixe_pkg::RESP_OKAY : ixe_pkg::RESP_SLVERR;
			end
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// AXI4-Lite read path
	// ----------------------------------------------------------------
	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= ixe_pkg::RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= ixe_pkg::RESP_OKAY;
			if (s_axi_araddr[7])
				s_axi_rdata <= {24'h000000, data_mem[s_axi_araddr[6:2]]};
			else
			begin
				unique case ({s_axi_araddr[7:2], 2'b00})
					ixe_pkg::REG_CMD:     s_axi_rdata <= cmd_reg;
					ixe_pkg::REG_ACC:     s_axi_rdata <= {24'h000000, acc_reg};
					ixe_pkg::REG_FLAGS:   s_axi_rdata <= {28'h0000000, flags_reg};
					ixe_pkg::REG_TBL_PTR: s_axi_rdata <= {16'h0000, tbl_ptr_hi_reg, tbl_ptr_lo_reg};
					ixe_pkg::REG_TBL_HI:  s_axi_rdata <= {24'h000000, tbl_hi_reg};
					ixe_pkg::REG_STATUS:  s_axi_rdata <= {30'h0, skipped_reg, busy};
					default:
					begin
						s_axi_rdata <= 32'h0000_0000;
						s_axi_rresp <= ixe_pkg::RESP_SLVERR;
					end
				endcase
			end
		end
		else if (s_axi_rvalid && s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

endmodule

// File: verif/ixe_monitor.sv
/*
 * Bus checker for the execution unit's register port.
 * Assumes it is bound to ixe_core and sees only that module's ports.
 */
`timescale 1ns/1ps
module ixe_monitor
(
	// Clock and reset
	input wire logic        aclk,
	input wire logic        aresetn,
	// Write side
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	// Read side
	input wire logic [7:0]  s_axi_araddr,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	property p_b_hold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("write answer dropped early");
	property p_b_drop;
		s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
	endproperty
	a_b_drop: assert property (p_b_drop) else $error("write answer repeated");
	property p_b_block;
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
	endproperty
	a_b_block: assert property (p_b_block) else $error("new write taken early");
	property p_b_time;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:5] s_axi_bvalid;
	endproperty
	a_b_time: assert property (p_b_time) else $error("write answer late");
	property p_r_hold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_r_hold: assert property (p_r_hold) else $error("read answer changed");
	property p_r_next;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_r_next: assert property (p_r_next) else $error("read answer late");
	property p_ar_block;
		s_axi_rvalid |-> !s_axi_arready;
	endproperty
	a_ar_block: assert property (p_ar_block) else $error("read taken while busy");
	property p_r_hole;
		s_axi_arvalid && s_axi_arready && s_axi_araddr inside {[8'h18:8'h7c]}
			|=> s_axi_rresp == ixe_pkg::RESP_SLVERR && s_axi_rdata == 32'h0;
	endproperty
	a_r_hole: assert property (p_r_hole) else $error("unmapped read not refused");
endmodule
bind ixe_core ixe_monitor mon_u (.*);

// File: verif/ixe_prog_model.sv
/*
 * Program memory loader: writes 16-bit table words into the unit.
 * Assumes the bench calls load right after a rising clock edge.
 */
`timescale 1ns/1ps
module ixe_prog_model
(
	// Clock
	input wire logic         aclk,
	// Load port
	output logic             prog_we,
	output logic      [7:0]  prog_addr,
	output logic      [15:0] prog_wdata
);
	initial
	begin
		prog_we = 1'b0;
		prog_addr = 8'h00;
		prog_wdata = 16'h0000;
	end
	// After a load the lines carry inverted junk so a stale value cannot pass.
	task automatic load(input logic [7:0] a, input logic [15:0] d);
		@(posedge aclk);
		prog_we <= 1'b1;
		prog_addr <= a;
		prog_wdata <= d;
		@(posedge aclk);
		prog_we <= 1'b0;
		prog_addr <= ~a;
		prog_wdata <= ~d;
	endtask
endmodule

// File: verif/testbench.sv
/*
 * Self-checking bench: commands go in over the register bus, results are read back.
 * Assumes ixe_core, ixe_pkg and the program loader model are compiled first.
 */
`timescale 1ns/1ps
module testbench;
	logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [7:0] s_axi_awaddr, s_axi_araddr, prog_addr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, rs, wr_resp;
	logic prog_we;
	logic [15:0] prog_wdata;
	int bad_count, samples_checked;
	logic [7:0] sa [4] = '{8'h18, 8'h80, 8'h80, 8'h7f};
	logic [7:0] sm [4] = '{8'h29, 8'h01, 8'h80, 8'h80};
	logic [4:0] so [4] = '{ixe_pkg::OP_SUB_ACC, ixe_pkg::OP_SUB_MEM, ixe_pkg::OP_SUB_IMM,
		ixe_pkg::OP_SUB_IMM};
	logic [4:0] bo [4] = '{ixe_pkg::OP_BIT_NZ_SKIP, ixe_pkg::OP_BIT_NZ_SKIP,
		ixe_pkg::OP_BIT_Z_SKIP, ixe_pkg::OP_BIT_Z_SKIP};
	logic [2:0] bb [4] = '{3'h3, 3'h0, 3'h0, 3'h4};
	logic [7:0] mv, r;

	ixe_core dut_u (.*);
	ixe_prog_model pm_u (.aclk(aclk), .prog_we(prog_we), .prog_addr(prog_addr),
		.prog_wdata(prog_wdata));

	// ----------------------------------------------------------------
	// Bus tasks and checks
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axi_awready === 1'b1)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1)
				s_axi_wvalid <= 1'b0;
		end
		while (s_axi_bvalid !== 1'b1);
		wr_resp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic axr(input logic [7:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axi_arready === 1'b1)
				s_axi_arvalid <= 1'b0;
		end
		while (s_axi_rvalid !== 1'b1);
		rd = s_axi_rdata;
		rs = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	task automatic wr8(input logic [7:0] a, input logic [7:0] v);
		axw(a, {24'h0, v}, 4'h1);
	endtask
	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		axr(a);
		chk(rd, {24'h0, e});
	endtask
	function automatic logic [7:0] ma(input logic [4:0] i);
		return {1'b1, i, 2'b00};
	endfunction
	// Runs one command, waits for idle, then compares the skip bit.
	task automatic run(input logic [4:0] op, input logic [2:0] b, input logic [4:0] m,
		input logic [7:0] imm, input logic sk);
		int n;
		axw(ixe_pkg::REG_CMD, {imm, 3'h0, m, 5'h0, b, 3'h0, op}, 4'hf);
		n = 0;
		do
		begin
			axr(ixe_pkg::REG_STATUS);
			n++;
		end
		while (rd[0] !== 1'b0 && n < 20);
		chk({31'h0, rd[0]}, 32'h0);
		chk({31'h0, rd[1]}, {31'h0, sk});
	endtask
	function automatic logic [7:0] subf(input logic [7:0] a, input logic [7:0] b);
		logic [7:0] d;
		d = a - b;
		return {4'h0, a[7] != b[7] && d[7] != a[7], d == 8'h00, a[3:0] >= b[3:0], a >= b};
	endfunction
	task automatic final_report;
		if (bad_count == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Clock, reset, watchdog and tests
	// ----------------------------------------------------------------
	initial
	begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end
	initial
	begin
		#40000;
		bad_count++;
		final_report();
	end
	initial
	begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		rchk(ixe_pkg::REG_ACC, ixe_pkg::ACC_RESET);
		rchk(ixe_pkg::REG_FLAGS, {4'h0, ixe_pkg::FLAGS_RESET});
		wr8(ixe_pkg::REG_FLAGS, 8'h0f);
		wr8(ma(0), 8'h00);
		wr8(ma(1), 8'h10);
		wr8(ma(2), 8'hff);
		wr8(ma(3), 8'hff);
		wr8(ma(4), 8'h00);
		run(ixe_pkg::OP_SET_BYTE, 3'h0, 5'd0, 8'h00, 1'b0);
		rchk(ma(0), 8'hff);
		run(ixe_pkg::OP_SET_BIT, 3'h3, 5'd1, 8'h00, 1'b0);
		rchk(ma(1), 8'h18);
		run(ixe_pkg::OP_INC_SKIP, 3'h0, 5'd2, 8'h00, 1'b1);
		rchk(ma(2), 8'h00);
		run(ixe_pkg::OP_INC_SKIP, 3'h0, 5'd2, 8'h00, 1'b0);
		rchk(ma(2), 8'h01);
		run(ixe_pkg::OP_INC_ACC_SKIP, 3'h0, 5'd2, 8'h00, 1'b0);
		rchk(ixe_pkg::REG_ACC, 8'h02);
		rchk(ma(2), 8'h01);
		run(ixe_pkg::OP_INC_ACC_SKIP, 3'h0, 5'd3, 8'h00, 1'b1);
		rchk(ixe_pkg::REG_ACC, 8'h00);
		rchk(ma(3), 8'hff);
		for (int i = 0; i < 4; i++)
			run(bo[i], bb[i], 5'd1, 8'h00, i[0] == 1'b0);
		run(ixe_pkg::OP_ZERO_SKIP, 3'h0, 5'd2, 8'h00, 1'b0);
		run(ixe_pkg::OP_ZERO_SKIP, 3'h0, 5'd4, 8'h00, 1'b1);
		rchk(ma(4), 8'h00);
		run(ixe_pkg::OP_COPY_SKIP, 3'h0, 5'd1, 8'h00, 1'b0);
		rchk(ixe_pkg::REG_ACC, 8'h18);
		run(ixe_pkg::OP_SWAP_MEM, 3'h0, 5'd1, 8'h00, 1'b0);
		rchk(ma(1), 8'h81);
		run(ixe_pkg::OP_SWAP_ACC, 3'h0, 5'd1, 8'h00, 1'b0);
		rchk(ixe_pkg::REG_ACC, 8'h18);
		rchk(ma(1), 8'h81);
		rchk(ixe_pkg::REG_FLAGS, 8'h0f);
		for (int i = 0; i < 4; i++)
		begin
			mv = (so[i] == ixe_pkg::OP_SUB_IMM) ? 8'h3c : sm[i];
			r = sa[i] - sm[i];
			wr8(ixe_pkg::REG_ACC, sa[i]);
			wr8(ma(5), mv);
			run(so[i], 3'h0, 5'd5, sm[i], 1'b0);
			rchk(ixe_pkg::REG_FLAGS, subf(sa[i], sm[i]));
			rchk(ixe_pkg::REG_ACC, so[i] == ixe_pkg::OP_SUB_MEM ? sa[i] : r);
			rchk(ma(5), so[i] == ixe_pkg::OP_SUB_MEM ? r : mv);
		end
		wr8(ixe_pkg::REG_FLAGS, 8'h0b);
		wr8(ixe_pkg::REG_ACC, 8'h5a);
		wr8(ma(6), 8'h5a);
		run(ixe_pkg::OP_XOR_ACC, 3'h0, 5'd6, 8'h00, 1'b0);
		rchk(ixe_pkg::REG_ACC, 8'h00);
		rchk(ixe_pkg::REG_FLAGS, 8'h0f);
		wr8(ixe_pkg::REG_ACC, 8'h0f);
		wr8(ma(6), 8'hf0);
		run(ixe_pkg::OP_XOR_MEM, 3'h0, 5'd6, 8'h00, 1'b0);
		rchk(ma(6), 8'hff);
		rchk(ixe_pkg::REG_FLAGS, 8'h0b);
		run(ixe_pkg::OP_XOR_IMM, 3'h0, 5'd6, 8'h0f, 1'b0);
		rchk(ixe_pkg::REG_ACC, 8'h00);
		rchk(ixe_pkg::REG_FLAGS, 8'h0f);
		pm_u.load(8'h12, 16'hbeef);
		pm_u.load(8'h34, 16'h1234);
		axw(ixe_pkg::REG_TBL_PTR, 32'h0000_0112, 4'h3);
		run(ixe_pkg::OP_TAB_PAGED, 3'h0, 5'd7, 8'h00, 1'b0);
		rchk(ma(7), 8'hef);
		rchk(ixe_pkg::REG_TBL_HI, 8'hbe);
		axw(ixe_pkg::REG_TBL_PTR, 32'h0000_0034, 4'h1);
		run(ixe_pkg::OP_TAB_LAST, 3'h0, 5'd8, 8'h00, 1'b0);
		rchk(ma(8), 8'h34);
		rchk(ixe_pkg::REG_TBL_HI, 8'h12);
		rchk(ixe_pkg::REG_FLAGS, 8'h0f);
		axr(8'h20);
		chk({30'h0, rs}, {30'h0, ixe_pkg::RESP_SLVERR});
		axw(8'h20, 32'h0000_00aa, 4'hf);
		chk({30'h0, wr_resp}, {30'h0, ixe_pkg::RESP_SLVERR});
		final_report();
	end
endmodule
